//--- core/sasc_pkg.sv
// Shared constants, types and helper functions of the serial converter control block
package sasc_pkg;

  // Control byte layout, bit positions within the byte
  localparam int START_POS  = 7;
  localparam int CHAN_MSB   = 6;
  localparam int CHAN_LSB   = 4;
  localparam int FIXED_POS  = 3;
  localparam int CFG_POS    = 2;
  localparam int PWR_MSB    = 1;
  localparam int PWR_LSB    = 0;

  // Power/clock field codes
  localparam logic [1:0] PWR_AUTO_PD = 2'h0;
  localparam logic [1:0] PWR_RSVD    = 2'h1;
  localparam logic [1:0] PWR_INT     = 2'h2;
  localparam logic [1:0] PWR_EXT     = 2'h3;

  // Channel select codes that map to an input pair
  localparam logic [2:0] CHAN_SEL_0 = 3'h1;
  localparam logic [2:0] CHAN_SEL_1 = 3'h5;
  localparam logic [2:0] CHAN_SEL_2 = 3'h2;
  localparam logic [2:0] CHAN_SEL_3 = 3'h6;

  // Receive bit counts: bits already held when the current bit is sampled
  localparam logic [2:0] RX_CNT_FIRST = 3'h1;
  localparam logic [2:0] RX_CNT_CHAN  = 3'h3;
  localparam logic [2:0] RX_CNT_CFG   = 3'h5;
  localparam logic [2:0] RX_CNT_LAST  = 3'h7;

  // Result word and approximation
  localparam int                 RESULT_W        = 16;
  localparam logic [15:0]        SAR_FIRST_TRIAL = 16'h8000;
  localparam logic [15:0]        TWOS_FLIP       = 16'h8000;
  localparam logic [3:0]         SAR_MSB_IDX     = 4'hF;

  // Reset values
  localparam logic       MODE_INT_RESET = 1'b0;
  localparam logic [1:0] PWR_RESET      = PWR_EXT;
  localparam logic [5:0] MUX_RESET      = 6'h00;

  // Internal conversion timing at the reference clock rate
  localparam int REF_CLK_MHZ       = 250;
  localparam int INT_CONV_MAX_NS   = 8000;
  localparam int INT_CONV_MAX_CYC  = INT_CONV_MAX_NS * REF_CLK_MHZ / 1000;
  localparam int INT_STEP_CYC      = INT_CONV_MAX_CYC / RESULT_W;

  typedef enum logic [1:0] {SASC_HUNT, SASC_RECV, SASC_EXT_CONV} sasc_link_state_t;
  typedef enum logic {SASC_IDLE, SASC_CONV} sasc_conv_state_t;

  // Mux setting {valid, pos_ch[1:0], neg_is_common, neg_ch[1:0]}
  function automatic logic [5:0] mux_decode(input logic [2:0] chan, input logic single);
    logic [5:0] m;
    m = 6'h00;
    case (chan)
      CHAN_SEL_0: m = single ? 6'h24 : 6'h21;
      CHAN_SEL_1: m = single ? 6'h2C : 6'h28;
      CHAN_SEL_2: m = single ? 6'h34 : 6'h33;
      CHAN_SEL_3: m = single ? 6'h3C : 6'h3A;
      default:    m = 6'h00;
    endcase
    return m;
  endfunction : mux_decode

  // One approximation step: keep decided bit, try the next lower one
  function automatic logic [15:0] sar_step(input logic [15:0] code, input logic [3:0] idx,
                                           input logic above);
    logic [15:0] r;
    r = code;
    r[idx] = above;
    if (idx != 4'h0) begin
      r[idx - 4'h1] = 1'b1;
    end
    return r;
  endfunction : sar_step

endpackage : sasc_pkg

//--- core/sasc_sync2.sv
// Two-stage synchroniser for a vector of independent levels
`timescale 1ns/1ps
`default_nettype none
module sasc_sync2 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      q        <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : sasc_sync2
`default_nettype wire

//--- core/sasc_top.sv
// Serial control, conversion sequencing and readout of a four-channel 16-bit converter
`timescale 1ns/1ps
`default_nettype none
module sasc_top #(
  parameter int STEP_CYC = sasc_pkg::INT_STEP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        shift_clock_pin,
  input  wire logic        chip_select_n,
  input  wire logic        serial_in,
  input  wire logic        cmp_above,
  output logic             serial_out,
  output logic             serial_out_oe,
  output logic             busy_out,
  output logic             busy_oe,
  output logic [15:0]      ext_trial_code,
  output logic [15:0]      int_trial_code,
  output logic             sample_track,
  output logic             mux_valid,
  output logic [1:0]       mux_pos_ch,
  output logic             mux_neg_common,
  output logic [1:0]       mux_neg_ch,
  output logic             int_clock_mode,
  output logic             low_power
);

  localparam int STEP_W = $clog2(STEP_CYC + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);

  // ---------------- Link domain (shift clock) ----------------
  sasc_pkg::sasc_link_state_t state_reg;
  sasc_pkg::sasc_link_state_t state_next;
  logic        frame_rst;
  logic [2:0]  rx_cnt_reg;
  logic [6:0]  rx_shift_reg;
  logic [7:0]  rx_byte;
  logic        rx_last;
  logic        rx_chan_now;
  logic        rx_cfg_now;
  logic        hunt_hit;
  logic        byte_done_reg;
  logic [3:0]  sar_idx_reg;
  logic        sar_decide;
  logic [15:0] sar_code_next;
  logic        dec_bit_reg;
  logic        dec_valid_reg;
  logic        ext_active_reg;
  logic        frame_live_reg;
  logic        busy_link_reg;
  logic [3:0]  rd_cnt_reg;
  logic        rd_fire;
  logic        rd_seen_reg;
  logic        done_tog_s;
  logic        start_ext;
  logic        start_int;
  logic        mode_int_next;
  logic [1:0]  pwr_field_reg;
  logic [1:0]  pwr_field_next;
  logic        conv_int_reg;
  logic        start_tog_reg;
  logic        pd00_reg;
  logic [2:0]  chan_reg;
  logic [2:0]  chan_next;
  logic        cfg_reg;
  logic        cfg_next;
  logic [5:0]  mux_next;

  // ---------------- Reference domain ----------------
  sasc_pkg::sasc_conv_state_t cstate_reg;
  logic [6:0]        ref_sync_q;
  logic              cs_n_s;
  logic              cmp_s;
  logic              start_tog_s;
  logic              ext_busy_s;
  logic              ext_active_s;
  logic              conv_int_s;
  logic              pd00_s;
  logic              start_seen_reg;
  logic              start_evt;
  logic [STEP_W-1:0] step_cnt_reg;
  logic              step_done;
  logic [3:0]        bit_idx_reg;
  logic [15:0]       int_step_code;
  logic [15:0]       int_result_reg;
  logic              done_tog_reg;

  // Frame state is cleared for as long as select is high
  assign frame_rst = reset | chip_select_n;

  // Control byte receive decode
  assign rx_byte     = {rx_shift_reg, serial_in};
  assign hunt_hit    = (state_reg == sasc_pkg::SASC_HUNT) & serial_in;
  assign rx_last     = (state_reg == sasc_pkg::SASC_RECV) & (rx_cnt_reg == sasc_pkg::RX_CNT_LAST);
  assign rx_chan_now = (state_reg == sasc_pkg::SASC_RECV) & (rx_cnt_reg == sasc_pkg::RX_CNT_CHAN);
  assign rx_cfg_now  = (state_reg == sasc_pkg::SASC_RECV) & (rx_cnt_reg == sasc_pkg::RX_CNT_CFG);

  // The finished byte starts a conversion in the mode that was already active
  assign start_ext = rx_last & ~int_clock_mode;
  assign start_int = rx_last & int_clock_mode;

  // Clock mode follows 10 and 11 only; 00 and reserved 01 keep the old mode
  assign pwr_field_next = rx_last ? rx_byte[sasc_pkg::PWR_MSB:sasc_pkg::PWR_LSB] : pwr_field_reg;
  assign mode_int_next  = (rx_last & (pwr_field_next == sasc_pkg::PWR_INT))  ? 1'b1 :
                          (rx_last & (pwr_field_next == sasc_pkg::PWR_EXT))  ? 1'b0 :
                          int_clock_mode;

  // Multiplexer setting as soon as the channel and config bits are known
  assign chan_next = rx_chan_now ? {rx_shift_reg[1:0], serial_in} : chan_reg;
  assign cfg_next  = rx_cfg_now ? serial_in : cfg_reg;
  assign mux_next  = sasc_pkg::mux_decode(chan_next, cfg_next);

  // External mode approximation step on each rising edge
  assign sar_decide    = (state_reg == sasc_pkg::SASC_EXT_CONV);
  assign sar_code_next = sasc_pkg::sar_step(ext_trial_code, sar_idx_reg, cmp_above);

  // Internal result readout begins when a new completion is seen inside a frame
  assign rd_fire = frame_live_reg & (done_tog_s != rd_seen_reg);

  // Link state sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sasc_pkg::SASC_HUNT: begin
        if (hunt_hit) begin
          state_next = sasc_pkg::SASC_RECV;
        end
      end
      sasc_pkg::SASC_RECV: begin
        if (start_ext) begin
          state_next = sasc_pkg::SASC_EXT_CONV;
        end else if (rx_last) begin
          state_next = sasc_pkg::SASC_HUNT;
        end
      end
      sasc_pkg::SASC_EXT_CONV: begin
        if (sar_idx_reg == 4'h0) begin
          state_next = sasc_pkg::SASC_HUNT;
        end
      end
      default: state_next = sasc_pkg::SASC_HUNT;
    endcase
  end

  // Receiver and external conversion, sampled on the rising edge
  always_ff @(posedge shift_clock_pin or posedge frame_rst) begin
    if (frame_rst) begin
      state_reg      <= sasc_pkg::SASC_HUNT;
      rx_cnt_reg     <= 3'h0;
      rx_shift_reg   <= 7'h00;
      byte_done_reg  <= 1'b0;
      sar_idx_reg    <= 4'h0;
      ext_trial_code <= 16'h0000;
      dec_bit_reg    <= 1'b0;
      dec_valid_reg  <= 1'b0;
      ext_active_reg <= 1'b0;
      sample_track   <= 1'b0;
      frame_live_reg <= 1'b0;
    end else begin
      state_reg      <= state_next;
      rx_cnt_reg     <= hunt_hit ? sasc_pkg::RX_CNT_FIRST :
                        (state_reg == sasc_pkg::SASC_RECV) ? rx_cnt_reg + 3'h1 : 3'h0;
      rx_shift_reg   <= rx_byte[6:0];
      byte_done_reg  <= start_ext;
      sar_idx_reg    <= start_ext ? sasc_pkg::SAR_MSB_IDX :
                        sar_decide ? sar_idx_reg - 4'h1 : sar_idx_reg;
      ext_trial_code <= start_ext ? sasc_pkg::SAR_FIRST_TRIAL :
                        sar_decide ? sar_code_next : ext_trial_code;
      dec_bit_reg    <= (sar_idx_reg == sasc_pkg::SAR_MSB_IDX) ? ~cmp_above : cmp_above;
      dec_valid_reg  <= sar_decide;
      ext_active_reg <= (state_next == sasc_pkg::SASC_EXT_CONV);
      sample_track   <= rx_chan_now | (sample_track & ~rx_last);
      frame_live_reg <= 1'b1;
    end
  end

  // Mode, power field and multiplexer, kept across frames
  always_ff @(posedge shift_clock_pin or posedge reset) begin
    if (reset) begin
      int_clock_mode <= sasc_pkg::MODE_INT_RESET;
      pwr_field_reg  <= sasc_pkg::PWR_RESET;
      pd00_reg       <= 1'b0;
      conv_int_reg   <= sasc_pkg::MODE_INT_RESET;
      start_tog_reg  <= 1'b0;
      chan_reg       <= 3'h0;
      cfg_reg        <= 1'b0;
      {mux_valid, mux_pos_ch, mux_neg_common, mux_neg_ch} <= sasc_pkg::MUX_RESET;
    end else begin
      int_clock_mode <= mode_int_next;
      pwr_field_reg  <= pwr_field_next;
      pd00_reg       <= (pwr_field_next == sasc_pkg::PWR_AUTO_PD);
      conv_int_reg   <= rx_last ? int_clock_mode : conv_int_reg;
      start_tog_reg  <= start_tog_reg ^ start_int;
      chan_reg       <= chan_next;
      cfg_reg        <= cfg_next;
      {mux_valid, mux_pos_ch, mux_neg_common, mux_neg_ch} <= mux_next;
    end
  end

  // Output bits change on the falling edge
  always_ff @(negedge shift_clock_pin or posedge frame_rst) begin
    if (frame_rst) begin
      busy_link_reg <= 1'b0;
      rd_cnt_reg    <= 4'h0;
      serial_out    <= 1'b0;
    end else begin
      busy_link_reg <= byte_done_reg;
      if (rd_fire) begin
        serial_out <= int_result_reg[sasc_pkg::RESULT_W-1];
        rd_cnt_reg <= sasc_pkg::SAR_MSB_IDX;
      end else if (rd_cnt_reg != 4'h0) begin
        serial_out <= int_result_reg[rd_cnt_reg - 4'h1];
        rd_cnt_reg <= rd_cnt_reg - 4'h1;
      end else if (dec_valid_reg) begin
        serial_out <= dec_bit_reg;
      end else begin
        serial_out <= 1'b0;
      end
    end
  end

  // Marks an internal result as taken, kept across frames
  always_ff @(negedge shift_clock_pin or posedge reset) begin
    if (reset) begin
      rd_seen_reg <= 1'b0;
    end else begin
      rd_seen_reg <= rd_fire ? done_tog_s : rd_seen_reg;
    end
  end

  // Completion toggle into the link domain
  sasc_sync2 #(
    .WIDTH     (1),
    .RESET_VAL (1'b0)
  ) u_sync_link (
    .clk (shift_clock_pin),
    .rst (reset),
    .d   (done_tog_reg),
    .q   (done_tog_s)
  );

  // ---------------- Reference domain logic ----------------

  // Pins and link levels into the reference domain
  sasc_sync2 #(
    .WIDTH     (7),
    .RESET_VAL (7'h40)
  ) u_sync_ref (
    .clk (ref_clk),
    .rst (reset),
    .d   ({chip_select_n, cmp_above, start_tog_reg, busy_link_reg, ext_active_reg,
           conv_int_reg, pd00_reg}),
    .q   (ref_sync_q)
  );

  assign {cs_n_s, cmp_s, start_tog_s, ext_busy_s, ext_active_s, conv_int_s, pd00_s} = ref_sync_q;

  // Internal conversion stepping
  assign start_evt     = (start_tog_s != start_seen_reg);
  assign step_done     = (step_cnt_reg == STEP_LAST);
  assign int_step_code = sasc_pkg::sar_step(int_trial_code, bit_idx_reg, cmp_s);

  // Internal clock conversion: one decision per step, 16 steps in at most 8 us
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cstate_reg     <= sasc_pkg::SASC_IDLE;
      start_seen_reg <= 1'b0;
      step_cnt_reg   <= {STEP_W{1'b0}};
      bit_idx_reg    <= 4'h0;
      int_trial_code <= 16'h0000;
      int_result_reg <= 16'h0000;
      done_tog_reg   <= 1'b0;
    end else begin
      case (cstate_reg)
        sasc_pkg::SASC_IDLE: begin
          if (start_evt) begin
            cstate_reg     <= sasc_pkg::SASC_CONV;
            start_seen_reg <= start_tog_s;
            step_cnt_reg   <= {STEP_W{1'b0}};
            bit_idx_reg    <= sasc_pkg::SAR_MSB_IDX;
            int_trial_code <= sasc_pkg::SAR_FIRST_TRIAL;
          end
        end
        sasc_pkg::SASC_CONV: begin
          step_cnt_reg <= step_done ? {STEP_W{1'b0}} : step_cnt_reg + STEP_W'(1);
          if (step_done) begin
            int_trial_code <= int_step_code;
            bit_idx_reg    <= bit_idx_reg - 4'h1;
            if (bit_idx_reg == 4'h0) begin
              int_result_reg <= int_step_code ^ sasc_pkg::TWOS_FLIP;
              done_tog_reg   <= ~done_tog_reg;
              cstate_reg     <= sasc_pkg::SASC_IDLE;
            end
          end
        end
        default: cstate_reg <= sasc_pkg::SASC_IDLE;
      endcase
    end
  end

  // Pin drivers and power state
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy_out      <= 1'b0;
      busy_oe       <= 1'b0;
      serial_out_oe <= 1'b0;
      low_power     <= 1'b0;
    end else begin
      busy_out      <= conv_int_s ? ((cstate_reg != sasc_pkg::SASC_CONV) & ~start_evt)
                       : ext_busy_s;
      busy_oe       <= ~cs_n_s | conv_int_s;
      serial_out_oe <= ~cs_n_s;
      low_power     <= pd00_s & (cstate_reg == sasc_pkg::SASC_IDLE) & ~start_evt
                       & ~ext_active_s;
    end
  end

endmodule : sasc_top
`default_nettype wire

//--- testbench/sasc_host_model.sv
// Host serial port model: frames control bytes and collects returned bits
`timescale 1ns/1ps
`default_nettype none
module sasc_host_model (
  output var logic  shift_clock_pin,
  output var logic  chip_select_n,
  output var logic  serial_in,
  input  wire logic serial_out_oe,
  input  wire logic serial_out,
  input  wire logic busy_out
);
  logic busy_seen;

  // Idle: deselected, clock parked low, data high
  initial begin
    shift_clock_pin = 1'b0;
    chip_select_n   = 1'b1;
    serial_in       = 1'b1;
    busy_seen       = 1'b0;
  end

  // Notes a busy pulse inside the current frame
  always @(posedge busy_out) begin
    busy_seen = 1'b1;
  end

  // Frame: nlead zeros, then cb every 24 clocks nrep times, 12 ns clock
  task automatic frame(input logic [7:0] cb, input int nlead, input int nclk, input int nrep,
                       output logic [31:0] rx);
    int k;
    rx = 32'h0000_0000;
    busy_seen = 1'b0;
    chip_select_n = 1'b0;
    #20;
    for (int i = 0; i < nclk; i++) begin
      k = i - nlead;
      serial_in = (k >= 0 && k < 24 * nrep && k % 24 < 8) ? cb[7 - k % 24] : 1'b0;
      #6;
      rx = {rx[30:0], serial_out_oe ? serial_out : ~serial_out};  // released line reads inverted
      shift_clock_pin = 1'b1;
      #6;
      shift_clock_pin = 1'b0;
      // Clock paused after the last channel bit to stretch acquisition
      if (cb[7] && k >= 0 && k < 24 * nrep && k % 24 == 3) begin
        #1700;
      end
    end
    #20;
    chip_select_n = 1'b1;  // clock held low until the next frame
    serial_in = 1'b1;      // a one while deselected must start nothing
    #20;
  endtask : frame
endmodule : sasc_host_model
`default_nettype wire

//--- testbench/sasc_top_checker.sv
// Port-level assertions for the serial converter control block
`timescale 1ns/1ps
`default_nettype none
module sasc_top_checker #(
  parameter int STEP_CYC = 4
) (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        shift_clock_pin,
  input wire logic        chip_select_n,
  input wire logic        serial_out_oe,
  input wire logic        busy_out,
  input wire logic        busy_oe,
  input wire logic [15:0] ext_trial_code,
  input wire logic        sample_track,
  input wire logic        mux_valid,
  input wire logic [1:0]  mux_pos_ch,
  input wire logic        mux_neg_common,
  input wire logic [1:0]  mux_neg_ch,
  input wire logic        int_clock_mode,
  input wire logic        low_power
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Cycles spent with busy low in internal mode
  logic [11:0] int_low_reg;
  logic [11:0] int_low_next;
  // Saturates so a very long low phase cannot wrap back under the limit
  assign int_low_next = (int_clock_mode && !busy_out) ?
                        int_low_reg + {11'h000, int_low_reg != 12'hFFF} : 12'h000;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) int_low_reg <= 12'h000;
    else int_low_reg <= int_low_next;
  end

  AST_OE_FLOAT: assert property (chip_select_n [*4] |-> !serial_out_oe)
    else $error("Serial output driven while deselected");
  AST_OE_DRIVE: assert property (!chip_select_n [*4] |-> serial_out_oe && busy_oe)
    else $error("Outputs not driven while selected");
  AST_BUSY_PULSE: assert property ($rose(busy_out) && !int_clock_mode
    && !chip_select_n |-> ##[2:4] !busy_out)
    else $error("External busy pulse longer than one shift period");
  // Link-side properties are sampled on the shift clock that launches them
  AST_DIFF_PAIR: assert property (@(posedge shift_clock_pin)
    mux_valid && !mux_neg_common && !sample_track |-> mux_neg_ch == (mux_pos_ch ^ 2'h1))
    else $error("Differential pair mismatch");
  AST_TRIAL_START: assert property (@(posedge shift_clock_pin)
    $fell(sample_track) && !$past(int_clock_mode) |-> ext_trial_code == 16'h8000)
    else $error("First trial code wrong at hold");
  AST_LP_WAKE: assert property ($fell(sample_track) |-> ##[1:8] !low_power)
    else $error("Low power not left at conversion start");
  AST_TRACK_LEN: assert property (@(posedge shift_clock_pin)
    $rose(sample_track) |-> sample_track [*4] ##1 !sample_track)
    else $error("Acquisition shorter than expected");
  AST_SEL_CLEAR: assert property (chip_select_n [*2] |-> !sample_track)
    else $error("Acquisition kept while deselected");
  AST_INT_BUSY_MAX: assert property (int_low_reg <= 12'h7D0)
    else $error("Internal conversion longer than limit");

  // Main scenarios reached
  cover property ($fell(sample_track));
  cover property ($rose(low_power));
  cover property (int_clock_mode && $rose(busy_out));
endmodule : sasc_top_checker

bind sasc_top sasc_top_checker #(.STEP_CYC(STEP_CYC)) u_sasc_top_checker (.ref_clk, .reset,
  .chip_select_n, .serial_out_oe, .busy_out, .busy_oe, .ext_trial_code, .sample_track,
  .mux_valid, .mux_pos_ch, .mux_neg_common, .mux_neg_ch, .int_clock_mode, .low_power,
  .shift_clock_pin);
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the serial converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        conv_int = 1'b0;
  logic [15:0] vin = 16'h0000;
  logic        shift_clock_pin, chip_select_n, serial_in, cmp_above, serial_out;
  logic        serial_out_oe, busy_out, busy_oe, sample_track, mux_valid, mux_neg_common;
  logic        int_clock_mode, low_power;
  logic [1:0]  mux_pos_ch, mux_neg_ch;
  logic [15:0] ext_trial_code, int_trial_code;
  int          bad_count = 0;
  int          checked = 0;
  logic [15:0] corner [4] = '{16'h7FFF, 16'h8000, 16'h0000, 16'hFFFF};
  logic [2:0]  chans [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
  logic [1:0]  flds [3] = '{2'h0, 2'h3, 2'h0};  // reserved code never sent

  sasc_top #(.STEP_CYC(4)) u_sasc_top (.ref_clk, .reset, .shift_clock_pin, .chip_select_n,
    .serial_in, .cmp_above, .serial_out, .serial_out_oe, .busy_out, .busy_oe, .ext_trial_code,
    .int_trial_code, .sample_track, .mux_valid, .mux_pos_ch, .mux_neg_common, .mux_neg_ch,
    .int_clock_mode, .low_power);
  sasc_host_model u_host (.shift_clock_pin, .chip_select_n, .serial_in, .serial_out_oe,
    .serial_out, .busy_out);

  // Comparator stand-in: held input against the trial code in use
  function automatic logic at_or_above(input logic [15:0] v, input logic [15:0] trial);
    return $signed(v) >= $signed(trial ^ 16'h8000);
  endfunction : at_or_above
  assign cmp_above = at_or_above(vin, conv_int ? int_trial_code : ext_trial_code);

  // Expected mux setting {valid, pos, neg_common, neg}
  function automatic logic [5:0] mux_exp(input logic [2:0] ch, input logic sgl);
    logic [1:0] p;
    p = (ch == 3'h1) ? 2'h0 : (ch == 3'h5) ? 2'h1 : (ch == 3'h2) ? 2'h2 : 2'h3;
    if (!(ch inside {3'h1, 3'h5, 3'h2, 3'h6})) return 6'h00;
    return {1'b1, p, sgl, sgl ? 2'h0 : p ^ 2'h1};
  endfunction : mux_exp

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // External conversion, 32-clock or back-to-back 24-clock framing
  task automatic ext_conv(input logic [7:0] cb, input int nrep);
    logic [31:0] rx;
    int          lead;
    conv_int = 1'b0;
    lead = $urandom_range(3);
    u_host.frame(cb, lead, lead + 24 * nrep + 8, nrep, rx);
    chk("ext_result", rx[22:7], vin);
    chk("ext_tail", rx[6:0], 7'h00);
    if (nrep == 2) chk("ext_lsb_overlap", rx[31], vin[0]);
    chk("ext_busy_pulse", u_host.busy_seen, 1'b1);
    chk("mux", {mux_valid, mux_pos_ch, mux_neg_common, mux_neg_ch}, mux_exp(cb[6:4], cb[2]));
    repeat (8) @(posedge ref_clk);
    #1;
    chk("ext_low_power", low_power, cb[1:0] == 2'h0);
    chk("ext_mode", int_clock_mode, cb[1:0] == 2'h2);
    chk("ext_oe_off", {serial_out_oe, busy_oe}, 2'h0);
  endtask : ext_conv

  // Internal conversion then a later readout frame
  task automatic int_conv(input logic [7:0] cb);
    logic [31:0] rx;
    int          w;
    vin = 16'($urandom);
    conv_int = 1'b1;
    u_host.frame(cb, 0, 8, 1, rx);
    @(posedge ref_clk);
    #1;
    chk("int_start", {busy_out, busy_oe, serial_out_oe, low_power}, 4'h4);
    w = 0;
    while (busy_out !== 1'b1 && w < 2100) begin
      @(posedge ref_clk);
      w++;
    end
    chk("int_busy_span", w <= 2000, 1'b1);
    repeat (8) @(posedge ref_clk);
    #1;
    chk("int_low_power", low_power, cb[1:0] == 2'h0);
    u_host.frame(8'h00, 0, 18, 1, rx);
    chk("int_result", rx[15:0], vin);
    chk("int_lead", rx[17:16], 2'h0);
  endtask : int_conv

  // Core clock
  always #2 ref_clk = ~ref_clk;

  // Watchdog well beyond the expected run length
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    logic [31:0] rx;
    logic [7:0]  cb;
    logic [1:0]  fld;
    void'($urandom(61878));
    repeat (4) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    chk("reset_state", {int_clock_mode, low_power, serial_out_oe, busy_oe, mux_valid}, 5'h00);
    u_host.frame(8'hFF, 0, 3, 1, rx);  // partial byte dropped by deselect
    for (int n = 0; n < 14; n++) begin
      vin = (n < 4) ? corner[n] : 16'($urandom);
      fld = (n == 0) ? 2'h3 : flds[$urandom_range(2)];  // mode set before power-down
      cb = {1'b1, (n < 8) ? chans[n % 4] : 3'($urandom), 1'b1, (n < 8) ? n[2] : 1'($urandom), fld};
      ext_conv(cb, (n % 3 == 2) ? 2 : 1);
    end
    ext_conv(8'h9E, 1);  // select internal; this conversion stays external
    int_conv(8'hD8);  // power-down keeps internal clocking
    int_conv(8'hEF);  // back to external from the next conversion
    chk("mode_back", int_clock_mode, 1'b0);
    vin = 16'($urandom);
    ext_conv(8'hAF, 1);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
